// [cmfe_far_end.sv]
// model of the a/d converter and the carrier tracking loop
`timescale 1ns/1ps
module cmfe_far_end (
  // clock
  input wire logic mclk,
  // pins toward the front end
  output logic [cmfe_pkg::SMP_W-1:0] iPin,
  output logic [cmfe_pkg::SMP_W-1:0] qPin,
  output logic acceptN,
  output logic serData,
  output logic serSync
);
  import cmfe_pkg::*;
  initial {iPin, qPin, acceptN, serData, serSync} = 23'h000004;
  // n samples back to back; idle lines show the inverse, not stale data
  task automatic put(input logic [SMP_W-1:0] i, q, input int n);
    repeat (n) begin
      @(posedge mclk);
      iPin <= i;
      qPin <= q;
      acceptN <= 1'b0;
    end
    @(posedge mclk);
    iPin <= ~i;
    qPin <= ~q;
    acceptN <= 1'b1;
  endtask
  // sync one clock ahead of the msb, then 32 bits
  task automatic shift(input logic [31:0] w);
    @(posedge mclk);
    serSync <= 1'b1;
    for (int b = 31; b >= 0; b--) begin
      @(posedge mclk);
      serSync <= 1'b0;
      serData <= w[b];
    end
    @(posedge mclk);
    serData <= ~w[0];
  endtask
endmodule

// [cmfe_fifo.sv]
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module cmfe_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // streams
  cmfe_stream_if.snk inp,
  cmfe_stream_if.src outp
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] count_q;
  wire push = inp.valid && inp.ready;
  wire pop = outp.valid && outp.ready;

  assign inp.ready = count_q != (AW+1)'(DEPTH);
  assign outp.valid = count_q != '0;
  assign outp.data = mem_q[rdPtr_q];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) wrPtr_q <= (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
      if (pop) rdPtr_q <= (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge mclk) begin
    if (push) mem_q[wrPtr_q] <= inp.data;
  end
endmodule

// [cmfe_pkg.sv]
// constants shared by the carrier mixer front end
package cmfe_pkg;
  localparam int SMP_W = 10;
  localparam int LO_W = 8;
  localparam int MIX_W = 19;
  localparam int GAIN_W = 8;
  localparam int GAIN_FRAC = 7;
  localparam int OUT_W = 21;
  localparam int ACC_W = 32;
  localparam int OFS_W = 32;
  localparam int PIN_W = 26;
  localparam int FIFO_DEPTH = 4;
  // tuning step at the reference rate
  localparam real REF_CLK_MHZ = 52.0;
  localparam real STEP_HZ = 0.012;
  localparam real STEPS_PER_CYCLE = REF_CLK_MHZ * 1.0E6 / STEP_HZ;
  localparam logic [4:0] SHIFT_LAST = 5'h1F;
  // register offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FREQ_HOLD = 8'h04;
  localparam logic [7:0] ADDR_FREQ = 8'h08;
  localparam logic [7:0] ADDR_OFFSET = 8'h0C;
  localparam logic [7:0] ADDR_GAIN = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  // field positions
  localparam int CTRL_OFFBIN = 0;
  localparam int CTRL_COMPLEX = 1;
  localparam int STAT_SHIFTING = 0;
  localparam int STAT_FULL = 1;
  localparam int STAT_DROP_LO = 16;
  // values after reset, and the drop count limit
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [31:0] FREQ_RST = 32'h0000_0000;
  localparam logic [GAIN_W-1:0] GAIN_RST = 8'h80;
  localparam logic [15:0] DROP_MAX = 16'hFFFF;
  // accept pin sits at bit 5 of the pin word and idles high
  localparam logic [PIN_W-1:0] PIN_RST = 26'h0000020;
  // quarter wave, amplitude 127, half-step phase offset
  localparam logic [6:0] QSIN [8] = '{7'h0C, 7'h25, 7'h3C, 7'h51,
                                      7'h62, 7'h70, 7'h7A, 7'h7E};
  typedef enum logic {SH_IDLE, SH_RUN} cmfe_shift_e;
endpackage

// [cmfe_stream_if.sv]
// valid/ready stream between front end and its fifo
`timescale 1ns/1ps
interface cmfe_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// [cmfe_top.sv]
// carrier mixer front end: capture, carrier nco, mixer, gain, fifo
// Contract
// - samples enter pipeline on rising edge only while accept input is low
// - software picks two's complement or offset binary sample format
// - real mode uses in-phase only; complex mode uses both inputs
// - carrier phase rotated 0/90/180/270 degrees by two select pins
// - load pin high on an edge copies holding register to frequency
// - offset word shifted in msb first, one bit per clock after sync
// - complex multiply with quadrature carrier moves channel to dc
// - phase accumulator wide enough for about 0.012 Hz step at 52 MHz
// - gain correction applied to both mixer products before output
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module cmfe_top (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // sample and control pins
  input wire logic [cmfe_pkg::SMP_W-1:0] inphaseSampleIn,
  input wire logic [cmfe_pkg::SMP_W-1:0] quadratureSampleIn,
  input wire logic sampleAcceptN,
  input wire logic [1:0] carrierPhaseSel,
  input wire logic carrierFreqLoad,
  input wire logic carrierOffsetSerial,
  input wire logic carrierOffsetSync,
  // mixed output stream
  output logic [cmfe_pkg::OUT_W-1:0] outIData,
  output logic [cmfe_pkg::OUT_W-1:0] outQData,
  output logic outValid,
  input wire logic outReady
);
  import cmfe_pkg::*;

  // every pin passes the same two stages, so sync and serial stay aligned
  logic [PIN_W-1:0] pinMeta_q;
  logic [PIN_W-1:0] pinSync_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      // idle pin levels, so no false capture follows reset
      pinMeta_q <= PIN_RST;
      pinSync_q <= PIN_RST;
    end else begin
      pinMeta_q <= {inphaseSampleIn, quadratureSampleIn, sampleAcceptN,
                    carrierPhaseSel, carrierFreqLoad, carrierOffsetSerial,
                    carrierOffsetSync};
      pinSync_q <= pinMeta_q;
    end
  end
  wire [SMP_W-1:0] iS = pinSync_q[25:16];
  wire [SMP_W-1:0] qS = pinSync_q[15:6];
  wire accNS = pinSync_q[5];
  wire [1:0] phSelS = pinSync_q[4:3];
  wire cfldS = pinSync_q[2];
  wire serS = pinSync_q[1];
  wire syncS = pinSync_q[0];

  // register file
  logic [1:0] ctrl_q;
  logic [ACC_W-1:0] freqHold_q;
  logic [ACC_W-1:0] freq_q;
  logic [OFS_W-1:0] offset_q;
  logic [GAIN_W-1:0] gain_q;
  logic [15:0] drops_q;
  logic [15:0] drops_d;
  logic [31:0] rdMux;
  wire offBin = ctrl_q[CTRL_OFFBIN];
  wire cplx = ctrl_q[CTRL_COMPLEX];
  wire wrCtrl = regWr && regAddr == ADDR_CTRL;
  wire wrHold = regWr && regAddr == ADDR_FREQ_HOLD;
  wire wrGain = regWr && regAddr == ADDR_GAIN;
  wire wrStat = regWr && regAddr == ADDR_STATUS;

  // serial offset receiver
  cmfe_shift_e shSt_q;
  logic [4:0] shCnt_q;
  logic [OFS_W-1:0] shReg_q;
  wire shStart = shSt_q == SH_IDLE && syncS;
  wire shDone = shSt_q == SH_RUN && shCnt_q == SHIFT_LAST;
  wire [OFS_W-1:0] shNext = {shReg_q[OFS_W-2:0], serS};

  // pipeline, frozen while the fifo is full and the gain stage holds a word
  logic run;
  logic capV_q;
  logic signed [SMP_W-1:0] capI_q;
  logic signed [SMP_W-1:0] capQ_q;
  logic mixV_q;
  logic signed [MIX_W-1:0] mixI_q;
  logic signed [MIX_W-1:0] mixQ_q;
  logic gV_q;
  logic signed [OUT_W-1:0] gI_q;
  logic signed [OUT_W-1:0] gQ_q;
  logic [ACC_W-1:0] phAcc_q;
  wire capture = run && !accNS;
  wire dropped = !run && !accNS;

  wire [SMP_W-1:0] iFmt = offBin ? {~iS[SMP_W-1], iS[SMP_W-2:0]} : iS;
  wire [SMP_W-1:0] qFmt = offBin ? {~qS[SMP_W-1], qS[SMP_W-2:0]} : qS;
  wire [ACC_W-1:0] phStep = freq_q + offset_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RST;
      freqHold_q <= FREQ_RST;
      gain_q <= GAIN_RST;
    end else begin
      if (wrCtrl) ctrl_q <= regWdata[1:0];
      if (wrHold) freqHold_q <= regWdata;
      if (wrGain) gain_q <= regWdata[GAIN_W-1:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      freq_q <= FREQ_RST;
    end else if (cfldS) begin
      freq_q <= freqHold_q;
    end
  end

  // a drop in the same cycle as the clear is still counted
  always_comb begin
    drops_d = wrStat ? '0 : drops_q;
    if (dropped && drops_d != DROP_MAX) drops_d = drops_d + 16'h0001;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      drops_q <= '0;
    end else begin
      drops_q <= drops_d;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shSt_q <= SH_IDLE;
      shCnt_q <= '0;
      shReg_q <= '0;
      offset_q <= '0;
    end else begin
      case (shSt_q)
        SH_IDLE: begin
          shCnt_q <= '0;
          if (syncS) shSt_q <= SH_RUN;
        end
        SH_RUN: begin
          shReg_q <= shNext;
          shCnt_q <= shCnt_q + 5'h01;
          if (shDone) begin
            offset_q <= shNext;
            shSt_q <= SH_IDLE;
          end
        end
        default: shSt_q <= SH_IDLE;
      endcase
    end
  end

  // carrier nco advances once per accepted sample
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phAcc_q <= '0;
    end else if (capture) begin
      phAcc_q <= phAcc_q + phStep;
    end
  end

  // sine of a 5-bit phase: quadrant plus 3-bit index into the quarter-wave table
  function automatic logic signed [LO_W-1:0] loAmp(input logic [4:0] ph);
    logic [6:0] mag;
    mag = ph[3] ? QSIN[3'h7 - ph[2:0]] : QSIN[ph[2:0]];
    loAmp = ph[4] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
  endfunction

  wire [1:0] loQuad = phAcc_q[ACC_W-1:ACC_W-2] + phSelS;
  wire [4:0] sinPh = {loQuad, phAcc_q[ACC_W-3:ACC_W-5]};
  wire [4:0] cosPh = {loQuad + 2'h1, phAcc_q[ACC_W-3:ACC_W-5]};
  wire signed [LO_W-1:0] sinV = loAmp(sinPh);
  wire signed [LO_W-1:0] cosV = loAmp(cosPh);

  // multiply by the conjugate carrier to move the channel to dc
  wire signed [MIX_W-1:0] mixI_d = capI_q * cosV + capQ_q * sinV;
  wire signed [MIX_W-1:0] mixQ_d = capQ_q * cosV - capI_q * sinV;
  wire signed [GAIN_W:0] gainS = $signed({1'b0, gain_q});
  wire signed [MIX_W+GAIN_W:0] prodI = mixI_q * gainS;
  wire signed [MIX_W+GAIN_W:0] prodQ = mixQ_q * gainS;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      capV_q <= 1'b0;
      mixV_q <= 1'b0;
      gV_q <= 1'b0;
    end else if (run) begin
      capV_q <= !accNS;
      mixV_q <= capV_q;
      gV_q <= mixV_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (capture) begin
      capI_q <= iFmt;
      capQ_q <= cplx ? qFmt : '0;
    end
    if (run) begin
      mixI_q <= mixI_d;
      mixQ_q <= mixQ_d;
      gI_q <= prodI[MIX_W+GAIN_W:GAIN_FRAC];
      gQ_q <= prodQ[MIX_W+GAIN_W:GAIN_FRAC];
    end
  end

  // output fifo; a full fifo stalls the whole pipeline once the gain stage holds a word
  cmfe_stream_if #(.W(2*OUT_W)) fin();
  cmfe_stream_if #(.W(2*OUT_W)) fout();
  assign fin.valid = gV_q;
  assign fin.data = {gI_q, gQ_q};
  assign run = fin.ready || !gV_q;
  assign fout.ready = outReady;
  assign outValid = fout.valid;
  assign outIData = fout.data[2*OUT_W-1:OUT_W];
  assign outQData = fout.data[OUT_W-1:0];

  cmfe_fifo #(.W(2*OUT_W), .DEPTH(FIFO_DEPTH)) uFifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .inp(fin),
    .outp(fout)
  );

  // register read path
  always_comb begin
    case (regAddr)
      ADDR_CTRL: rdMux = {30'h0, ctrl_q};
      ADDR_FREQ_HOLD: rdMux = freqHold_q;
      ADDR_FREQ: rdMux = freq_q;
      ADDR_OFFSET: rdMux = offset_q;
      ADDR_GAIN: rdMux = {24'h0, gain_q};
      ADDR_STATUS: rdMux = {drops_q, 14'h0, !fin.ready, shSt_q == SH_RUN};
      default: rdMux = 32'h0;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= '0;
    end else begin
      regRdata <= regRd ? rdMux : 32'h0;
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_capture_gate: assert property (
    $rose(mixV_q) |-> $past(!pinSync_q[5], 2) || $past(capV_q, 2))
    else $error("sample entered while accept was high");

  a_offset_binary: assert property (
    capture && offBin && cplx |=> capQ_q[SMP_W-1] == !$past(qS[SMP_W-1]))
    else $error("offset binary msb not inverted");

  a_real_zero: assert property (
    capture && !cplx |=> capQ_q == '0 && capI_q == $past(iFmt))
    else $error("real mode quadrature not zero");

  a_phase_rotate: assert property (
    phSelS == 2'h2 |-> sinV == -loAmp({phAcc_q[31:30], phAcc_q[29:27]}))
    else $error("180 degree rotation wrong");

  a_freq_load: assert property (
    cfldS |=> freq_q == $past(freqHold_q))
    else $error("frequency not loaded");

  a_freq_hold: assert property (
    !cfldS |=> $stable(freq_q))
    else $error("frequency changed without load");

  a_offset_frame: assert property (
    shStart |-> ##32 shDone)
    else $error("offset word not 32 bits after sync");

  a_offset_msb: assert property (
    shStart ##1 1'b1 |=> ##31 offset_q[OFS_W-1] == $past(serS, 32))
    else $error("offset msb not first bit");

  a_mixer_real: assert property (
    run && capV_q && capQ_q == '0 |=>
      mixQ_q == -($past(capI_q) * $past(sinV)))
    else $error("mixer quadrature product wrong");

  a_nco_step: assert property (
    capture |=> phAcc_q == $past(phAcc_q) + $past(freq_q + offset_q))
    else $error("phase step not frequency plus offset");

  a_nco_hold: assert property (
    !capture |=> $stable(phAcc_q))
    else $error("phase moved without a sample");

  a_gain_unity: assert property (
    run && gain_q == GAIN_RST |=> gI_q == OUT_W'($past(mixI_q)))
    else $error("unity gain changed the product");

  a_drop_count: assert property (
    dropped && !wrStat && drops_q != DROP_MAX |=>
      drops_q == $past(drops_q) + 16'h0001)
    else $error("dropped sample not counted");

  a_status_clear: assert property (
    wrStat && !dropped |=> drops_q == 16'h0000)
    else $error("drop count not cleared by write");

  a_pipe_freeze: assert property (
    !run |=> $stable(capV_q) && $stable(mixV_q) && $stable(gV_q))
    else $error("pipeline advanced while stalled");

  a_stall_hold: assert property (
    !run |=> $stable(gI_q) && $stable(gQ_q))
    else $error("gain stage changed while stalled");

  a_out_stands: assert property (
    outValid && !outReady |=>
      outValid && $stable(outIData) && $stable(outQData))
    else $error("output word changed before it was taken");

  a_shift_busy: assert property (
    shSt_q == SH_RUN && !shDone |=> shSt_q == SH_RUN)
    else $error("offset shift ended early");

  a_offset_stands: assert property (
    !shDone |=> $stable(offset_q))
    else $error("offset word changed outside a frame end");

  a_read_idle: assert property (
    !regRd |=> regRdata == 32'h0)
    else $error("read data outside a read cycle");

  c_offset_loaded: cover property (shDone);
  c_freq_loaded: cover property (cfldS ##1 !cfldS);
  c_fifo_full: cover property (!fin.ready ##1 dropped);
  c_complex_out: cover property (cplx && outValid && outReady);
endmodule

// [testbench.sv]
// self-checking bench for the carrier mixer front end
`timescale 1ns/1ps
module testbench;
  import cmfe_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} cmfe_row_s;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [1:0] phSel = 2'h0;
  logic freqLoad = 1'b0;
  logic outReady = 1'b1;
  logic [31:0] regRdata;
  logic [SMP_W-1:0] iPin, qPin;
  logic acceptN, serData, serSync, outValid;
  logic [OUT_W-1:0] outI, outQ;
  int bad_count = 0;
  int checks_done = 0;
  cmfe_row_s rows [7] = '{
    '{ADDR_CTRL, 32'h3, 32'h3},
    '{ADDR_FREQ_HOLD, 32'hA5A5_5A5A, 32'hA5A5_5A5A},
    '{ADDR_FREQ, 32'hFFFF_FFFF, 32'h0},
    '{ADDR_OFFSET, 32'hFFFF_FFFF, 32'h0},
    '{ADDR_GAIN, 32'h0000_01C3, 32'h0000_00C3},
    '{8'h18, 32'h1234_5678, 32'h0},
    '{ADDR_STATUS, 32'hFFFF_FFFF, 32'h0}};
  always #2.5 mclk = ~mclk;
  cmfe_far_end far (.mclk(mclk), .iPin(iPin), .qPin(qPin),
    .acceptN(acceptN), .serData(serData), .serSync(serSync));
  cmfe_top uut (.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .inphaseSampleIn(iPin), .quadratureSampleIn(qPin),
    .sampleAcceptN(acceptN), .carrierPhaseSel(phSel),
    .carrierFreqLoad(freqLoad), .carrierOffsetSerial(serData),
    .carrierOffsetSync(serSync), .outIData(outI), .outQData(outQ),
    .outValid(outValid), .outReady(outReady));
  task automatic chk(input string n, input logic signed [31:0] e, g);
    checks_done++;
    if (e !== g) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= w;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1;
    d = regRdata;
  endtask
  // one sample through an empty pipe; popped right after it is read
  task automatic get(input logic [SMP_W-1:0] i, q,
                     output logic signed [OUT_W-1:0] oi, oq);
    int k = 0;
    far.put(i, q, 1);
    while (outValid !== 1'b1 && k < 20) begin
      @(posedge mclk);
      #1;
      k++;
    end
    chk("outValid", 32'h1, {31'h0, outValid});
    oi = outI;
    oq = outQ;
    @(posedge mclk);
    #1;
  endtask
  task automatic phase(input logic [1:0] p);
    @(posedge mclk);
    phSel <= p;
    repeat (3) @(posedge mclk);
  endtask
  task automatic give_verdict;
    if (bad_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge mclk);
    bad_count++;
    give_verdict();
  end
  initial begin
    logic signed [OUT_W-1:0] aI, aQ, bI, bQ, cI, cQ;
    logic [31:0] d;
    int pops = 0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    foreach (rows[r]) begin
      wr(rows[r].a, rows[r].w);
      rd(rows[r].a, d);
      chk("reg", rows[r].e, d);
    end
    @(posedge mclk) rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    rd(ADDR_GAIN, d);
    chk("gainRst", {24'h0, GAIN_RST}, d);
    rd(ADDR_FREQ_HOLD, d);
    chk("holdRst", FREQ_RST, d);
    // acc stays put while increment is zero, so outputs are comparable
    wr(ADDR_CTRL, 32'h2);
    get(10'h064, 10'h3CE, aI, aQ);
    // phase zero: cosine is the top table entry, sine the first
    chk("mixI", 100 * int'(QSIN[7]) - 50 * int'(QSIN[0]), aI);
    chk("mixQ", -50 * int'(QSIN[7]) - 100 * int'(QSIN[0]), aQ);
    phase(2'h2);
    get(10'h064, 10'h3CE, bI, bQ);
    chk("ph180I", -aI, bI);
    chk("ph180Q", -aQ, bQ);
    phase(2'h1);
    get(10'h064, 10'h3CE, cI, cQ);
    phase(2'h3);
    get(10'h064, 10'h3CE, bI, bQ);
    chk("ph270I", -cI, bI);
    chk("ph270Q", -cQ, bQ);
    phase(2'h0);
    wr(ADDR_GAIN, 32'h40);
    get(10'h064, 10'h3CE, bI, bQ);
    chk("halfI", aI >>> 1, bI);
    chk("halfQ", aQ >>> 1, bQ);
    wr(ADDR_GAIN, 32'h80);
    wr(ADDR_CTRL, 32'h3);
    get(10'h264, 10'h1CE, bI, bQ);
    chk("offbinI", aI, bI);
    chk("offbinQ", aQ, bQ);
    wr(ADDR_CTRL, 32'h2);
    get(10'h0C8, 10'h39C, bI, bQ);
    chk("dblI", 2 * aI, bI);
    chk("dblQ", 2 * aQ, bQ);
    get(10'h064, 10'h000, cI, cQ);
    wr(ADDR_CTRL, 32'h0);
    get(10'h064, 10'h17B, bI, bQ);
    chk("realI", cI, bI);
    chk("realQ", cQ, bQ);
    far.put(10'h155, 10'h2AA, 0);
    d = 32'h0;
    repeat (10) begin
      @(posedge mclk);
      #1;
      d[0] = d[0] | outValid;
    end
    chk("noAccept", 32'h0, d);
    wr(ADDR_FREQ_HOLD, 32'h1234_5678);
    @(posedge mclk) freqLoad <= 1'b1;
    @(posedge mclk) freqLoad <= 1'b0;
    repeat (4) @(posedge mclk);
    wr(ADDR_FREQ_HOLD, 32'h0BAD_F00D);
    rd(ADDR_FREQ, d);
    chk("freq", 32'h1234_5678, d);
    fork
      far.shift(32'hC3A5_0F81);
      begin
        repeat (12) @(posedge mclk);
        rd(ADDR_STATUS, d);
        chk("shifting", 32'h1, {31'h0, d[STAT_SHIFTING]});
      end
    join
    repeat (2) @(posedge mclk);
    rd(ADDR_OFFSET, d);
    chk("offset", 32'hC3A5_0F81, d);
    // sink stalls: fifo fills, later samples are dropped
    @(posedge mclk) outReady <= 1'b0;
    far.put(10'h064, 10'h3CE, 12);
    repeat (8) @(posedge mclk);
    rd(ADDR_STATUS, d);
    chk("full", 32'h1, {31'h0, d[STAT_FULL]});
    // 12 sent: fifo and the three pipeline stages keep 7
    chk("drops", 32'h5, {16'h0, d[31:16]});
    @(posedge mclk) outReady <= 1'b1;
    repeat (20) begin
      @(posedge mclk);
      #1;
      pops += int'(outValid);
    end
    chk("drained", 32'h1, {31'h0, pops >= FIFO_DEPTH && !outValid});
    give_verdict();
  end
endmodule
